/* File: logic/rsps_pkg.sv */
// constants, types and register map of the reset supervisor block
// assumes one 50 MHz system clock; oscillator clocks counted as mclk cycles
package rsps_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_ISS        = 8'hC5;
  localparam logic [7:0] ADDR_SAS        = 8'hF7;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h80;
  localparam logic [7:0] ADDR_WDOG_CTRL  = 8'h81;
  localparam logic [7:0] ADDR_CLK_CTRL   = 8'h82;

  // field positions
  localparam int ISS_PF_BIT  = 7;
  localparam int ISS_HI_BIT  = 6;
  localparam int ISS_LO_BIT  = 5;
  localparam int ISS_TX1_BIT = 3;
  localparam int ISS_RX1_BIT = 2;
  localparam int ISS_TX0_BIT = 1;
  localparam int ISS_RX0_BIT = 0;
  localparam int SAS_TX2_BIT = 1;
  localparam int SAS_RX2_BIT = 0;
  localparam int PC_IDLE_BIT = 0;
  localparam int PC_OFE_BIT  = 4;
  localparam int PC_OFF_BIT  = 5;
  localparam int WD_POR_BIT  = 6;
  localparam int WD_EPWE_BIT = 5;
  localparam int WD_EPWF_BIT = 4;
  localparam int CK_DIV_HI   = 7;
  localparam int CK_DIV_LO   = 6;

  // reset values and encodings
  localparam logic [1:0]  CLK_DIV_RESET = 2'h2;
  localparam logic [1:0]  CLK_DIV_SLOW  = 2'h3;
  localparam logic [15:0] PF_VECTOR     = 16'h0033;
  localparam logic [15:0] FETCH_ADDR    = 16'h0000;

  // timing
  localparam int CLK_HZ          = 50_000_000;
  localparam int OSC_START_CLKS  = 65536;
  localparam int MC_SYS_CLKS     = 4;
  localparam int WDT_RST_MC      = 2;
  localparam int WDT_RST_CYCLES  = WDT_RST_MC * MC_SYS_CLKS;
  localparam int EXT_RST_MC_X100 = 125;
  // strictly below 1.25 machine cycles
  localparam int EXT_RST_CYCLES  = (EXT_RST_MC_X100 * MC_SYS_CLKS) / 100 - 1;
  localparam int SLOW_DIV        = 256;
  localparam int CNT_W           = 17;
  localparam int DIV_W           = 9;

  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_HOLD  = 2'h1,
    ST_COUNT = 2'h3
  } rsps_state_t;

  typedef enum logic [1:0] {
    SRC_POWER = 2'h0,
    SRC_OSC   = 2'h1,
    SRC_EXT   = 2'h2,
    SRC_WDT   = 2'h3
  } rsps_src_t;

  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_HIGH = 2'h1,
    LVL_PF   = 2'h2
  } rsps_lvl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsps_bus_req_t;

  typedef struct packed {
    logic [2:0] tx;
    logic [2:0] rx;
  } rsps_serial_t;

endpackage

/* File: logic/rsps_sync.sv */
// two-flop synchroniser for asynchronous levels
// assumes levels stay stable for several clock cycles
`timescale 1ns/10ps
module rsps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* File: logic/rsps_cnt.sv */
// loadable down counter with a zero flag
// assumes load and reset come from logic on the same clock
`timescale 1ns/10ps
module rsps_cnt #(
  parameter int W = 17
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  logic [W-1:0] count;

  always_ff @(posedge clk)
  begin
    if (rst)
      count <= '0;
    else if (load)
      count <= load_val;
    else if (count != '0)
      count <= count - 1'b1;
  end

  assign done = (count == '0);

endmodule

/* File: logic/rsps_top.sv */
// reset supervisor, power status, clock divisor lockout and idle control
// assumes cpu, timed-access unit and serial ports share mclk
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
// Function
// - three interrupt service levels: power-fail highest, then high, then low
// - status bits 7,6,5 read 1 while power-fail, high, low levels serve
// - serial transmit and receive activity bits: ports 0 and 1 in ISS, port 2 in SAS
// - clock divisor writes ignored while any serial port is busy
// - enabled oscillator-fail detection holds the device in reset
// - oscillator-fail enable at power bit 4, writable only by timed access
// - oscillator failure sets flag bit 5; cleared by power reset or 0 write
// - oscillator-fail detector ignores an oscillator halted by stop mode
// - either supply below reset threshold holds reset; full reset on recovery
// - after supply recovery count 65,536 clocks, then fetch from zero
// - power-on reset sets watchdog bit 6; software reads then clears it
// - enabled early power warning vectors to 0033h at highest priority
// - early power warning interrupt enabled only by watchdog bit 5
// - warning sets watchdog bit 4 regardless of enable; software clears it
// - reset output low for pin, watchdog, oscillator and power-fail resets
// - reset output 65,536 clocks long, under 1.25 or two machine cycles
// - writing 1 to power bit 0 enters idle; clocks keep running
// - any interrupt or reset leaves idle mode
// - divisor value 11b selects slow mode dividing the clock by 256
module rsps_top
  import rsps_pkg::*;
#(
  parameter int START_CLKS = OSC_START_CLKS
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire rsps_bus_req_t bus_req,
  output logic        [7:0]  bus_rdata,
  input  wire logic          ta_window,
  input  wire logic          rst_pin,
  input  wire logic          wdt_timeout,
  input  wire logic          osc_low,
  input  wire logic          stop_mode,
  input  wire logic   [1:0]  supply_low_rst,
  input  wire logic   [1:0]  supply_low_warn,
  input  wire rsps_serial_t  serial,
  input  wire logic          irq_pending,
  input  wire logic          int_ack,
  input  wire rsps_lvl_t     int_ack_level,
  input  wire logic          int_return,
  output logic               reset_out_n,
  output logic               core_reset,
  output logic               fetch_start,
  output logic        [15:0] fetch_addr,
  output logic               idle,
  output logic        [1:0]  clock_divisor_field,
  output logic               slow_clock_mode,
  output logic               sys_tick,
  output logic               mach_tick,
  output logic               early_power_warning_interrupt,
  output logic        [15:0] pf_vector
);

  localparam logic [CNT_W-1:0] START_LOAD = CNT_W'(START_CLKS - 1);
  localparam logic [CNT_W-1:0] WDT_LOAD   = CNT_W'(WDT_RST_CYCLES - 1);
  localparam logic [CNT_W-1:0] EXT_LOAD   = CNT_W'(EXT_RST_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_LOAD   = DIV_W'(SLOW_DIV - 1);
  localparam logic [1:0]       MC_LAST    = 2'(MC_SYS_CLKS - 1);

  rsps_state_t      state;
  rsps_state_t      next_state;
  rsps_src_t        kind;
  rsps_src_t        next_kind;
  logic             cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic             cnt_done;
  logic             div_done;
  logic             ext_s;
  logic             osc_low_s;
  logic [1:0]       low_rst_s;
  logic [1:0]       low_warn_s;
  logic             pwr_low;
  logic             warn_any;
  logic             osc_trip;
  logic             hold_src;
  logic             in_rst;
  logic             rst_all;
  logic             pwr_hold;
  logic             ser_busy;
  logic             wr_pc;
  logic             wr_wd;
  logic             wr_ck;
  logic             osc_fail_enable;
  logic             osc_fail_flag;
  logic             por_flag;
  logic             early_power_warning_enable;
  logic             epw_flag;
  logic [2:0]       in_service;
  logic [2:0]       next_in_service;
  logic [1:0]       mc_phase;
  logic [7:0]       rd_val;

  rsps_sync #(
    .W (6)
  ) u_sync (
    .clk (mclk),
    .rst (sys_rst),
    .d   ({rst_pin, osc_low, supply_low_rst, supply_low_warn}),
    .q   ({ext_s, osc_low_s, low_rst_s, low_warn_s})
  );

  assign pwr_low  = |low_rst_s;
  assign warn_any = |low_warn_s;
  // stopped oscillator in stop mode is intentional, not a failure
  assign osc_trip = osc_fail_enable & osc_low_s & ~stop_mode;
  assign in_rst   = (state != ST_RUN);
  assign rst_all  = sys_rst | in_rst;
  assign pwr_hold = (state == ST_HOLD) && (kind == SRC_POWER);
  assign ser_busy = |{serial.tx, serial.rx};
  assign wr_pc    = bus_req.wr && !in_rst && (bus_req.addr == ADDR_POWER_CTRL);
  assign wr_wd    = bus_req.wr && !in_rst && (bus_req.addr == ADDR_WDOG_CTRL);
  assign wr_ck    = bus_req.wr && !in_rst && (bus_req.addr == ADDR_CLK_CTRL);

  always_comb
  begin
    case (kind)
      SRC_POWER: hold_src = pwr_low;
      SRC_OSC:   hold_src = osc_low_s & ~stop_mode;
      SRC_EXT:   hold_src = ext_s;
      default:   hold_src = 1'b0;
    endcase
  end

  // power loss preempts every other source
  always_comb
  begin
    next_state = state;
    next_kind  = kind;
    cnt_load   = 1'b0;
    cnt_val    = START_LOAD;
    if (pwr_low)
    begin
      next_state = ST_HOLD;
      next_kind  = SRC_POWER;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          if (osc_trip)
          begin
            next_state = ST_HOLD;
            next_kind  = SRC_OSC;
          end
          else if (ext_s)
          begin
            next_state = ST_HOLD;
            next_kind  = SRC_EXT;
          end
          else if (wdt_timeout)
          begin
            next_state = ST_COUNT;
            next_kind  = SRC_WDT;
            cnt_load   = 1'b1;
            cnt_val    = WDT_LOAD;
          end
        end
        ST_HOLD:
        begin
          if (!hold_src)
          begin
            next_state = ST_COUNT;
            cnt_load   = 1'b1;
            // 65,536 clocks for power and oscillator sources
            cnt_val    = (kind == SRC_EXT) ? EXT_LOAD : START_LOAD;
          end
        end
        ST_COUNT:
        begin
          if (osc_trip)
          begin
            next_state = ST_HOLD;
            next_kind  = SRC_OSC;
          end
          else if (ext_s)
          begin
            next_state = ST_HOLD;
            next_kind  = SRC_EXT;
          end
          else if (cnt_done)
            next_state = ST_RUN;
        end
        default:
          next_state = ST_HOLD;
      endcase
    end
  end

  rsps_cnt #(
    .W (CNT_W)
  ) u_rst_cnt (
    .clk      (mclk),
    .rst      (sys_rst),
    .load     (cnt_load),
    .load_val (cnt_val),
    .done     (cnt_done)
  );

  // sys_rst acts like a supply recovery
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= ST_HOLD;
      kind  <= SRC_POWER;
    end
    else
    begin
      state <= next_state;
      kind  <= next_kind;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      reset_out_n <= 1'b0;
      core_reset  <= 1'b1;
      fetch_start <= 1'b0;
      fetch_addr  <= FETCH_ADDR;
    end
    else
    begin
      reset_out_n <= !in_rst;
      core_reset  <= in_rst;
      fetch_start <= (state == ST_COUNT) && (next_state == ST_RUN);
      fetch_addr  <= FETCH_ADDR;
    end
  end

  // interrupt service levels
  always_comb
  begin
    next_in_service = in_service;
    if (int_return)
    begin
      if (in_service[2])
        next_in_service[2] = 1'b0;
      else if (in_service[1])
        next_in_service[1] = 1'b0;
      else
        next_in_service[0] = 1'b0;
    end
    if (int_ack)
    begin
      case (int_ack_level)
        LVL_PF:   next_in_service[2] = 1'b1;
        LVL_HIGH: next_in_service[1] = 1'b1;
        LVL_LOW:  next_in_service[0] = 1'b1;
        default:  next_in_service    = in_service;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst_all)
      in_service <= '0;
    else
      in_service <= next_in_service;
  end

  always_ff @(posedge mclk)
  begin
    if (rst_all)
      idle <= 1'b0;
    else if (irq_pending || int_ack)
      idle <= 1'b0;
    else if (wr_pc && bus_req.wdata[PC_IDLE_BIT])
      idle <= 1'b1;
  end

  // enable survives its own oscillator reset, else a failure during the count would not trip again
  always_ff @(posedge mclk)
  begin
    if (sys_rst || pwr_hold)
      osc_fail_enable <= 1'b0;
    else if (wr_pc && ta_window)
      osc_fail_enable <= bus_req.wdata[PC_OFE_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      osc_fail_flag <= 1'b0;
    else if (osc_trip)
      osc_fail_flag <= 1'b1;
    else if (pwr_hold)
      osc_fail_flag <= 1'b0;
    else if (wr_pc && !bus_req.wdata[PC_OFF_BIT])
      osc_fail_flag <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || pwr_hold)
      por_flag <= 1'b1;
    else if (wr_wd && !bus_req.wdata[WD_POR_BIT])
      por_flag <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      epw_flag <= 1'b0;
    else if (warn_any)
      epw_flag <= 1'b1;
    else if (wr_wd && !bus_req.wdata[WD_EPWF_BIT])
      epw_flag <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst_all)
      early_power_warning_enable <= 1'b0;
    else if (wr_wd)
      early_power_warning_enable <= bus_req.wdata[WD_EPWE_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (rst_all)
    begin
      early_power_warning_interrupt <= 1'b0;
      pf_vector                     <= PF_VECTOR;
    end
    else
    begin
      early_power_warning_interrupt <=
        early_power_warning_enable & epw_flag;
      pf_vector                     <= PF_VECTOR;
    end
  end

  // lockout protects serial frames from a mid-character rate change
  always_ff @(posedge mclk)
  begin
    if (rst_all)
    begin
      clock_divisor_field <= CLK_DIV_RESET;
      slow_clock_mode     <= 1'b0;
    end
    else if (wr_ck && !ser_busy)
    begin
      clock_divisor_field <= bus_req.wdata[CK_DIV_HI:CK_DIV_LO];
      slow_clock_mode     <=
        (bus_req.wdata[CK_DIV_HI:CK_DIV_LO] == CLK_DIV_SLOW);
    end
  end

  rsps_cnt #(
    .W (DIV_W)
  ) u_slow_div (
    .clk      (mclk),
    .rst      (rst_all || !slow_clock_mode),
    .load     (div_done),
    .load_val (DIV_LOAD),
    .done     (div_done)
  );

  // multiplier sources are outside this block; other settings tick every cycle outside reset
  assign sys_tick  = slow_clock_mode ? div_done : !in_rst;
  assign mach_tick = sys_tick && (mc_phase == MC_LAST);

  always_ff @(posedge mclk)
  begin
    if (rst_all)
      mc_phase <= '0;
    else if (sys_tick)
      mc_phase <= mc_phase + 2'h1;
  end

  always_comb
  begin
    rd_val = 8'h00;
    case (bus_req.addr)
      ADDR_ISS:
      begin
        rd_val[ISS_PF_BIT]  = in_service[2];
        rd_val[ISS_HI_BIT]  = in_service[1];
        rd_val[ISS_LO_BIT]  = in_service[0];
        rd_val[ISS_TX1_BIT] = serial.tx[1];
        rd_val[ISS_RX1_BIT] = serial.rx[1];
        rd_val[ISS_TX0_BIT] = serial.tx[0];
        rd_val[ISS_RX0_BIT] = serial.rx[0];
      end
      ADDR_SAS:
      begin
        rd_val[SAS_TX2_BIT] = serial.tx[2];
        rd_val[SAS_RX2_BIT] = serial.rx[2];
      end
      ADDR_POWER_CTRL:
      begin
        rd_val[PC_IDLE_BIT] = idle;
        rd_val[PC_OFE_BIT]  = osc_fail_enable;
        rd_val[PC_OFF_BIT]  = osc_fail_flag;
      end
      ADDR_WDOG_CTRL:
      begin
        rd_val[WD_POR_BIT]  = por_flag;
        rd_val[WD_EPWE_BIT] = early_power_warning_enable;
        rd_val[WD_EPWF_BIT] = epw_flag;
      end
      ADDR_CLK_CTRL:
        rd_val[CK_DIV_HI:CK_DIV_LO] = clock_divisor_field;
      default:
        rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || !bus_req.rd)
      bus_rdata <= 8'h00;
    else
      bus_rdata <= rd_val;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_status_levels: assert property (
    bus_req.rd && bus_req.addr == ADDR_ISS
    |=> bus_rdata[7:5] == $past(in_service))
    else $error("service level bits wrong");
  a_div_lockout: assert property (
    wr_ck && ser_busy && !in_rst |=> $stable(clock_divisor_field))
    else $error("divisor changed while serial busy");
  a_slow_tick_gap: assert property (
    slow_clock_mode && sys_tick |=> (!sys_tick || !slow_clock_mode) [*8])
    else $error("slow tick too frequent");
  a_osc_trip_rst: assert property (
    state == ST_RUN && osc_trip && !pwr_low
    |=> state == ST_HOLD && osc_fail_flag ##1 !reset_out_n)
    else $error("oscillator failure not reset");
  a_ofe_guard: assert property (
    !ta_window && !pwr_hold |=> $stable(osc_fail_enable))
    else $error("enable changed without timed access");
  a_stop_no_flag: assert property (
    $rose(osc_fail_flag) |-> $past(!stop_mode))
    else $error("flag set during stop mode");
  a_pwr_hold: assert property (
    pwr_low |-> ##2 !reset_out_n)
    else $error("supply low without reset out");
  a_por_flag: assert property (
    pwr_hold |=> por_flag)
    else $error("power-on flag not set");
  a_warn_flag: assert property (
    warn_any |=> epw_flag)
    else $error("warning flag not set");
  a_warn_irq_gate: assert property (
    early_power_warning_interrupt |-> $past(early_power_warning_enable))
    else $error("warning interrupt without enable");
  a_wdt_length: assert property (
    (state == ST_RUN && wdt_timeout && !pwr_low && !osc_trip && !ext_s)
    ##1 (!pwr_low && !osc_trip && !ext_s) [*8]
    |=> !reset_out_n ##1 reset_out_n)
    else $error("watchdog reset length wrong");
  a_idle_exit: assert property (
    idle && irq_pending |=> !idle)
    else $error("idle not left on interrupt");
  a_fetch_after: assert property (
    fetch_start |-> reset_out_n == 1'b0 && fetch_addr == FETCH_ADDR)
    else $error("fetch start misplaced");

  c_power_done: cover property (pwr_hold ##[1:1000] fetch_start);
  c_wdt_reset: cover property (wdt_timeout && state == ST_RUN);
  c_slow_mode: cover property ($rose(slow_clock_mode));
  c_osc_trip: cover property (osc_trip);

endmodule

/* File: tb/rsps_board.sv */
// board model: reset pin, supply monitor, oscillator detector
// assumes reset_out_n is sampled on the rising mclk edge
`timescale 1ns/10ps
module rsps_board (
  input  wire logic       mclk,
  input  wire logic       reset_out_n,
  output logic            rst_pin,
  output logic      [1:0] supply_low_rst,
  output logic      [1:0] supply_low_warn,
  output logic            osc_low,
  output int              low_len
);
  int cnt;

  initial
  begin
    rst_pin = 1'b0;
    supply_low_rst = 2'h0;
    supply_low_warn = 2'h0;
    osc_low = 1'b0;
    low_len = 0;
    cnt = 0;
  end

  // width of the current or last low pulse; final as soon as the output rises
  always @(posedge mclk)
  begin
    if (!reset_out_n)
    begin
      cnt <= cnt + 1;
      low_len <= cnt + 1;
    end
    else
      cnt <= 0;
  end

  // pushbutton style pin: high for n edges
  task automatic hold_pin(input int n);
    @(posedge mclk) rst_pin <= 1'b1;
    repeat (n) @(posedge mclk);
    rst_pin <= 1'b0;
  endtask

  // one supply dips below its reset threshold for n edges
  task automatic hold_supply(input int idx, input int n);
    @(posedge mclk) supply_low_rst[idx] <= 1'b1;
    repeat (n) @(posedge mclk);
    supply_low_rst[idx] <= 1'b0;
  endtask

  task automatic hold_osc(input int n);
    @(posedge mclk) osc_low <= 1'b1;
    repeat (n) @(posedge mclk);
    osc_low <= 1'b0;
  endtask

  task automatic set_warn(input logic [1:0] v);
    @(posedge mclk) supply_low_warn <= v;
  endtask
endmodule

/* File: tb/tb_reset_supervisor_and_power_status.sv */
// self-checking bench for the reset supervisor top
// assumes the board model drives pin, supplies and oscillator level
`timescale 1ns/10ps
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module tb_reset_supervisor_and_power_status;
  import rsps_pkg::*;
  // short start-up count keeps the run small
  localparam int START = 16;
  logic          mclk, sys_rst, ta_window, wdt_timeout, stop_mode;
  logic          irq_pending, int_ack, int_return;
  rsps_bus_req_t req;
  rsps_serial_t  ser;
  rsps_lvl_t     ack_lvl;
  logic [7:0]    bus_rdata, d;
  logic [15:0]   fetch_addr, pf_vector;
  logic [1:0]    clock_divisor_field, slr, slw;
  logic          reset_out_n, core_reset, fetch_start, idle, slow_clock_mode;
  logic          sys_tick, mach_tick, ewi, rst_pin, osc_low;
  int            low_len, mismatches, cmp_count, n;
  logic          fetch_prev;

  rsps_top #(.START_CLKS(START)) i_rsps_top (
    .mclk(mclk), .sys_rst(sys_rst), .bus_req(req), .bus_rdata(bus_rdata),
    .ta_window(ta_window), .rst_pin(rst_pin), .wdt_timeout(wdt_timeout),
    .osc_low(osc_low), .stop_mode(stop_mode), .supply_low_rst(slr),
    .supply_low_warn(slw), .serial(ser), .irq_pending(irq_pending),
    .int_ack(int_ack), .int_ack_level(ack_lvl), .int_return(int_return),
    .reset_out_n(reset_out_n), .core_reset(core_reset),
    .fetch_start(fetch_start), .fetch_addr(fetch_addr), .idle(idle),
    .clock_divisor_field(clock_divisor_field),
    .slow_clock_mode(slow_clock_mode), .sys_tick(sys_tick),
    .mach_tick(mach_tick), .early_power_warning_interrupt(ewi),
    .pf_vector(pf_vector));

  rsps_board i_rsps_board (
    .mclk(mclk), .reset_out_n(reset_out_n), .rst_pin(rst_pin),
    .supply_low_rst(slr), .supply_low_warn(slw), .osc_low(osc_low),
    .low_len(low_len));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // fetch_start leads the reset output rise by one edge
  always @(posedge mclk)
    fetch_prev <= fetch_start;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one edge, then let its updates settle
  task automatic step(input int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 q = bus_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic ta = 1'b0);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    ta_window <= ta;
    @(posedge mclk);
    req.wr <= 1'b0;
    ta_window <= 1'b0;
    #1;
  endtask

  // bounded wait for the reset output to reach a level
  task automatic wait_out(input logic v);
    int i;
    for (i = 0; i < 3000 && reset_out_n !== v; i++)
      step();
    if (i == 3000)
    begin
      mismatches++;
      final_report();
    end
  endtask

  task automatic pulse_ack(input rsps_lvl_t l, input logic ret);
    @(posedge mclk);
    int_ack <= !ret;
    ack_lvl <= l;
    int_return <= ret;
    @(posedge mclk);
    int_ack <= 1'b0;
    int_return <= 1'b0;
    #1;
  endtask

  task automatic tick_gap(output int g);
    int i;
    for (i = 0; i < 600 && sys_tick !== 1'b1; i++)
      step();
    g = 0;
    do
    begin
      step();
      g++;
    end while (sys_tick !== 1'b1 && g < 600);
    if (i == 600 || g == 600)
    begin
      mismatches++;
      final_report();
    end
  endtask

  logic [7:0] lvl_exp [6] = '{8'h20, 8'h60, 8'hE0, 8'h60, 8'h20, 8'h00};

  initial
  begin
    {ta_window, wdt_timeout, stop_mode, irq_pending} = 4'h0;
    {int_ack, int_return} = 2'h0;
    req = '0;
    ser = '0;
    ack_lvl = LVL_LOW;
    mismatches = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    wait_out(1'b1);
    `CHK(fetch_prev, 1'b1)
    `CHK(fetch_start, 1'b0)
    `CHK(core_reset, 1'b0)
    `CHK(fetch_addr, FETCH_ADDR)
    rd(ADDR_WDOG_CTRL, d);
    `CHK(d[WD_POR_BIT], 1'b1)
    wr(ADDR_WDOG_CTRL, 8'h00);
    rd(ADDR_WDOG_CTRL, d);
    `CHK(d, 8'h00)
    $display("test reset done");

    // serial activity, service levels, unmapped read
    ser.tx = 3'h5;
    ser.rx = 3'h2;
    rd(ADDR_ISS, d);
    `CHK(d, {4'h0, ser.tx[1], ser.rx[1], ser.tx[0], ser.rx[0]})
    rd(ADDR_SAS, d);
    `CHK(d[1:0], {ser.tx[2], ser.rx[2]})
    rd(8'h3C, d);
    `CHK(d, 8'h00)
    ser = '0;
    for (int i = 0; i < 6; i++)
    begin
      pulse_ack(rsps_lvl_t'(i), i > 2);
      rd(ADDR_ISS, d);
      `CHK(d, lvl_exp[i])
    end
    $display("test status done");

    // divisor lockout, slow mode entered from a low service level
    pulse_ack(LVL_LOW, 1'b0);
    ser.tx = 3'h1;
    wr(ADDR_CLK_CTRL, 8'hC0);
    step();
    `CHK(clock_divisor_field, CLK_DIV_RESET)
    ser = '0;
    wr(ADDR_CLK_CTRL, 8'hC0);
    step();
    `CHK(clock_divisor_field, CLK_DIV_SLOW)
    `CHK(slow_clock_mode, 1'b1)
    tick_gap(n);
    `CHK(n, SLOW_DIV)
    wr(ADDR_CLK_CTRL, 8'h80);
    pulse_ack(LVL_LOW, 1'b1);
    step();
    `CHK(slow_clock_mode, 1'b0)
    $display("test divisor done");

    // oscillator-fail enable, stop mode immunity, trip
    wr(ADDR_POWER_CTRL, 8'h10);
    rd(ADDR_POWER_CTRL, d);
    `CHK(d[PC_OFE_BIT], 1'b0)
    wr(ADDR_POWER_CTRL, 8'h10, 1'b1);
    rd(ADDR_POWER_CTRL, d);
    `CHK(d[PC_OFE_BIT], 1'b1)
    stop_mode <= 1'b1;
    i_rsps_board.hold_osc(5);
    for (int i = 0; i < 8; i++)
    begin
      step();
      `CHK(reset_out_n, 1'b1)
    end
    stop_mode <= 1'b0;
    i_rsps_board.hold_osc(5);
    wait_out(1'b0);
    wait_out(1'b1);
    `CHK(low_len, 5 + START)
    rd(ADDR_POWER_CTRL, d);
    `CHK(d[PC_OFF_BIT], 1'b1)
    wr(ADDR_POWER_CTRL, 8'h10, 1'b1);
    rd(ADDR_POWER_CTRL, d);
    `CHK(d[PC_OFF_BIT], 1'b0)
    wr(ADDR_POWER_CTRL, 8'h00, 1'b1);
    $display("test oscillator done");

    // power warning flag, enable and interrupt
    i_rsps_board.set_warn(2'h2);
    i_rsps_board.set_warn(2'h0);
    step(4);
    rd(ADDR_WDOG_CTRL, d);
    `CHK(d[WD_EPWF_BIT], 1'b1)
    `CHK(ewi, 1'b0)
    wr(ADDR_WDOG_CTRL, 8'h30);
    step(2);
    `CHK(ewi, 1'b1)
    `CHK(pf_vector, PF_VECTOR)
    wr(ADDR_WDOG_CTRL, 8'h20);
    step(2);
    `CHK(ewi, 1'b0)
    $display("test warning done");

    // idle entry and exits
    wr(ADDR_POWER_CTRL, 8'h01);
    `CHK(idle, 1'b1)
    `CHK(sys_tick, 1'b1)
    n = 0;
    for (int i = 0; i < 8; i++)
    begin
      step();
      n = n + int'(mach_tick);
    end
    `CHK(n, 2)
    `CHK(idle, 1'b1)
    @(posedge mclk);
    irq_pending <= 1'b1;
    @(posedge mclk);
    irq_pending <= 1'b0;
    #1 `CHK(idle, 1'b0)
    wr(ADDR_POWER_CTRL, 8'h01);
    @(posedge mclk);
    wdt_timeout <= 1'b1;
    @(posedge mclk);
    wdt_timeout <= 1'b0;
    wait_out(1'b0);
    wait_out(1'b1);
    `CHK(idle, 1'b0)
    `CHK(low_len, WDT_RST_CYCLES)
    $display("test idle done");

    // pin and supply resets; supply clears oscillator state
    i_rsps_board.hold_pin(3);
    wait_out(1'b0);
    `CHK(core_reset, 1'b1)
    wait_out(1'b1);
    `CHK(low_len, 3 + EXT_RST_CYCLES)
    wr(ADDR_POWER_CTRL, 8'h10, 1'b1);
    i_rsps_board.hold_osc(2);
    wait_out(1'b0);
    wait_out(1'b1);
    i_rsps_board.hold_supply(0, 3);
    wait_out(1'b0);
    wait_out(1'b1);
    `CHK(low_len, 3 + START)
    `CHK(fetch_prev, 1'b1)
    rd(ADDR_POWER_CTRL, d);
    `CHK(d[PC_OFF_BIT], 1'b0)
    rd(ADDR_WDOG_CTRL, d);
    `CHK(d[WD_POR_BIT], 1'b1)
    i_rsps_board.hold_supply(1, 4);
    wait_out(1'b0);
    wait_out(1'b1);
    `CHK(low_len, 4 + START)
    $display("test resets done");
    final_report();
  end
endmodule
